// ### uaid_defines.vh
// register map, field positions and constants of the serial interrupt qualifier
`ifndef UAID_DEFINES_VH
`define UAID_DEFINES_VH

// axi4-lite word addresses
`define UAID_ADDR_W 4
`define UAID_OFS_CTRL_ONE 4'h0
`define UAID_OFS_CTRL_TWO 4'h4
`define UAID_OFS_IRQ_CTRL 4'h8
`define UAID_OFS_STATUS 4'hc

// axi response codes
`define UAID_RESP_OKAY 2'h0
`define UAID_RESP_SLVERR 2'h2

// uart_ctrl_one fields
`define UAID_C1_PORT_ON 0
`define UAID_C1_NINE_BIT 1
`define UAID_C1_PARITY_EN 2
`define UAID_C1_W 3
`define UAID_C1_RST 3'h0

// uart_ctrl_two fields
`define UAID_C2_RECEIVER_ON 0
`define UAID_C2_ADDR_DET 1
`define UAID_C2_WAKE_EN 2
`define UAID_C2_RX_IRQ_EN 3
`define UAID_C2_TXE_IRQ_EN 4
`define UAID_C2_TXI_IRQ_EN 5
`define UAID_C2_W 6
`define UAID_C2_RST 6'h00

// interrupt controller enables
`define UAID_IC_GLOBAL 0
`define UAID_IC_UART 1
`define UAID_IC_W 2
`define UAID_IC_RST 2'h0

// uart_status_reg fields
`define UAID_ST_RX_AVAIL 0
`define UAID_ST_OVERRUN 1
`define UAID_ST_TX_EMPTY 2
`define UAID_ST_TX_IDLE 3
`define UAID_ST_ADDR_WORD 4
`define UAID_ST_STARTUP 5
`define UAID_ST_W 6
`define UAID_ST_RST 6'h00

// received word layout
`define UAID_WORD_W 9
`define UAID_BIT_NINE 8
`define UAID_BIT_EIGHT 7

// wake sequencer
`define UAID_WK_IDLE 1'b0
`define UAID_WK_START 1'b1
`define UAID_CNT_W 16
`define UAID_STARTUP_DEF 16'h0400
`define UAID_CNT_ONE 16'h0001
`define UAID_CNT_ZERO 16'h0000

`endif

// ### uaid_irq_qualifier.v
// serial-port interrupt qualifier with address detect and rx wake-up
`timescale 1ns/1ns
`include "uaid_defines.vh"

module uaid_irq_qualifier #(
	parameter [`UAID_CNT_W-1:0] STARTUP_CYCLES = `UAID_STARTUP_DEF
) (
	input wire i_clk,
	input wire i_sys_rst,
	// axi4-lite slave
	input wire [`UAID_ADDR_W-1:0] i_s_axi_awaddr,
	input wire i_s_axi_awvalid,
	output reg o_s_axi_awready,
	input wire [31:0] i_s_axi_wdata,
	input wire [3:0] i_s_axi_wstrb,
	input wire i_s_axi_wvalid,
	output reg o_s_axi_wready,
	output reg [1:0] o_s_axi_bresp,
	output reg o_s_axi_bvalid,
	input wire i_s_axi_bready,
	input wire [`UAID_ADDR_W-1:0] i_s_axi_araddr,
	input wire i_s_axi_arvalid,
	output reg o_s_axi_arready,
	output reg [31:0] o_s_axi_rdata,
	output reg [1:0] o_s_axi_rresp,
	output reg o_s_axi_rvalid,
	input wire i_s_axi_rready,
	// serial unit status
	input wire i_rx_avail_flag,
	input wire [`UAID_WORD_W-1:0] i_rx_head_word,
	input wire i_overrun_flag,
	input wire i_tx_empty_flag,
	input wire i_tx_idle_flag,
	input wire i_rx_pin,
	// power state
	input wire i_power_down,
	input wire i_idle_zero_mode,
	input wire i_sleep_mode,
	// to serial unit and cpu
	output reg o_nine_bit_sel,
	output reg o_parity_en,
	output reg o_port_on,
	output reg o_receiver_on,
	output reg o_tx_run,
	output reg o_rx_run,
	output reg o_rx_discard,
	output reg o_wake,
	output reg o_uart_irq
);

////////////////////////////////////////////////////////////////////////////////
// declarations

reg [`UAID_C1_W-1:0] uart_ctrl_one_reg;
reg [`UAID_C2_W-1:0] uart_ctrl_two_reg;
reg [`UAID_IC_W-1:0] irq_ctrl_reg;
reg [`UAID_ST_W-1:0] uart_status_reg;
reg [`UAID_ST_W-1:0] status_next;
reg aw_got_reg;
reg w_got_reg;
reg [`UAID_ADDR_W-1:0] aw_addr_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;
reg wk_state_reg;
reg wk_state_next;
reg [`UAID_CNT_W-1:0] wk_cnt_reg;
reg [`UAID_CNT_W-1:0] wk_cnt_next;
reg rx_prev_reg;
reg wake_irq_next;
reg irq_next;
reg [31:0] rdata_next;
reg rresp_err;
wire aw_hs;
wire w_hs;
wire do_write;
wire ar_hs;
wire [`UAID_ADDR_W-1:0] wr_addr;
wire [31:0] wr_data;
wire wr_lane0;
wire top_bit;
wire wake_armed;
wire rx_fall;
wire rx_irq_en;
wire src_rx;
wire src_ovr;
wire src_txe;
wire src_txi;

////////////////////////////////////////////////////////////////////////////////
// axi write channel

assign aw_hs = i_s_axi_awvalid & o_s_axi_awready;
assign w_hs = i_s_axi_wvalid & o_s_axi_wready;
assign wr_addr = aw_got_reg ? aw_addr_reg : i_s_axi_awaddr;
assign wr_data = w_got_reg ? w_data_reg : i_s_axi_wdata;
assign wr_lane0 = w_got_reg ? w_strb_reg[0] : i_s_axi_wstrb[0];
// write completes once both address and data are in hand
assign do_write = (aw_got_reg | aw_hs) & (w_got_reg | w_hs) & ~o_s_axi_bvalid;

always @(posedge i_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		o_s_axi_awready <= 1'b0;
		o_s_axi_wready <= 1'b0;
		o_s_axi_bvalid <= 1'b0;
		o_s_axi_bresp <= `UAID_RESP_OKAY;
		aw_got_reg <= 1'b0;
		w_got_reg <= 1'b0;
		aw_addr_reg <= {`UAID_ADDR_W{1'b0}};
		w_data_reg <= 32'h0000_0000;
		w_strb_reg <= 4'h0;
	end else begin
		if (do_write) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			o_s_axi_awready <= 1'b0;
			o_s_axi_wready <= 1'b0;
			o_s_axi_bvalid <= 1'b1;
			case (wr_addr)
			`UAID_OFS_CTRL_ONE, `UAID_OFS_CTRL_TWO, `UAID_OFS_IRQ_CTRL: begin
				o_s_axi_bresp <= `UAID_RESP_OKAY;
			end
			// status is read-only; writes are accepted and dropped
			`UAID_OFS_STATUS: begin
				o_s_axi_bresp <= `UAID_RESP_OKAY;
			end
			default: begin
				o_s_axi_bresp <= `UAID_RESP_SLVERR;
			end
			endcase
		end else begin
			if (aw_hs) begin
				aw_got_reg <= 1'b1;
				aw_addr_reg <= i_s_axi_awaddr;
			end
			if (w_hs) begin
				w_got_reg <= 1'b1;
				w_data_reg <= i_s_axi_wdata;
				w_strb_reg <= i_s_axi_wstrb;
			end
			if (o_s_axi_bvalid & i_s_axi_bready) begin
				o_s_axi_bvalid <= 1'b0;
			end
			o_s_axi_awready <= ~aw_got_reg & ~aw_hs & ~o_s_axi_bvalid;
			o_s_axi_wready <= ~w_got_reg & ~w_hs & ~o_s_axi_bvalid;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// control registers, untouched by power-down

always @(posedge i_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		uart_ctrl_one_reg <= `UAID_C1_RST;
		uart_ctrl_two_reg <= `UAID_C2_RST;
		irq_ctrl_reg <= `UAID_IC_RST;
	end else if (do_write & wr_lane0) begin
		case (wr_addr)
		`UAID_OFS_CTRL_ONE: begin
			uart_ctrl_one_reg <= wr_data[`UAID_C1_W-1:0];
		end
		`UAID_OFS_CTRL_TWO: begin
			uart_ctrl_two_reg <= wr_data[`UAID_C2_W-1:0];
		end
		`UAID_OFS_IRQ_CTRL: begin
			irq_ctrl_reg <= wr_data[`UAID_IC_W-1:0];
		end
		default: begin
			irq_ctrl_reg <= irq_ctrl_reg;
		end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// axi read channel

assign ar_hs = i_s_axi_arvalid & o_s_axi_arready;

always @* begin
	rdata_next = 32'h0000_0000;
	rresp_err = 1'b0;
	case (i_s_axi_araddr)
	`UAID_OFS_CTRL_ONE: begin
		rdata_next[`UAID_C1_W-1:0] = uart_ctrl_one_reg;
	end
	`UAID_OFS_CTRL_TWO: begin
		rdata_next[`UAID_C2_W-1:0] = uart_ctrl_two_reg;
	end
	`UAID_OFS_IRQ_CTRL: begin
		rdata_next[`UAID_IC_W-1:0] = irq_ctrl_reg;
	end
	`UAID_OFS_STATUS: begin
		rdata_next[`UAID_ST_W-1:0] = uart_status_reg;
	end
	default: begin
		rresp_err = 1'b1;
	end
	endcase
end

always @(posedge i_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		o_s_axi_arready <= 1'b0;
		o_s_axi_rvalid <= 1'b0;
		o_s_axi_rdata <= 32'h0000_0000;
		o_s_axi_rresp <= `UAID_RESP_OKAY;
	end else if (ar_hs) begin
		o_s_axi_arready <= 1'b0;
		o_s_axi_rvalid <= 1'b1;
		o_s_axi_rdata <= rdata_next;
		o_s_axi_rresp <= rresp_err ? `UAID_RESP_SLVERR : `UAID_RESP_OKAY;
	end else if (o_s_axi_rvalid) begin
		if (i_s_axi_rready) begin
			o_s_axi_rvalid <= 1'b0;
		end
	end else begin
		o_s_axi_arready <= 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// address detect qualification

// top bit depends on word length
assign top_bit = uart_ctrl_one_reg[`UAID_C1_NINE_BIT] ?
	i_rx_head_word[`UAID_BIT_NINE] : i_rx_head_word[`UAID_BIT_EIGHT];
assign rx_irq_en = uart_ctrl_two_reg[`UAID_C2_RX_IRQ_EN];
// data-available reaches the request only for address words when detect is on
assign src_rx = rx_irq_en & i_rx_avail_flag &
	(~uart_ctrl_two_reg[`UAID_C2_ADDR_DET] | top_bit);
assign src_ovr = rx_irq_en & i_overrun_flag;
assign src_txe = uart_ctrl_two_reg[`UAID_C2_TXE_IRQ_EN] & i_tx_empty_flag;
assign src_txi = uart_ctrl_two_reg[`UAID_C2_TXI_IRQ_EN] & i_tx_idle_flag;

////////////////////////////////////////////////////////////////////////////////
// rx wake-up sequencer

assign wake_armed = uart_ctrl_two_reg[`UAID_C2_WAKE_EN] &
	uart_ctrl_one_reg[`UAID_C1_PORT_ON] &
	uart_ctrl_two_reg[`UAID_C2_RECEIVER_ON] & rx_irq_en;
assign rx_fall = rx_prev_reg & ~i_rx_pin;

always @* begin
	wk_state_next = wk_state_reg;
	wk_cnt_next = wk_cnt_reg;
	wake_irq_next = 1'b0;
	case (wk_state_reg)
	`UAID_WK_IDLE: begin
		if (i_power_down & (i_idle_zero_mode | i_sleep_mode) & wake_armed & rx_fall) begin
			wk_state_next = `UAID_WK_START;
			wk_cnt_next = STARTUP_CYCLES;
		end
	end
	`UAID_WK_START: begin
		if (wk_cnt_reg <= `UAID_CNT_ONE) begin
			wk_state_next = `UAID_WK_IDLE;
			wk_cnt_next = `UAID_CNT_ZERO;
			wake_irq_next = 1'b1;
		end else begin
			wk_cnt_next = wk_cnt_reg - `UAID_CNT_ONE;
		end
	end
	default: begin
		wk_state_next = `UAID_WK_IDLE;
		wk_cnt_next = `UAID_CNT_ZERO;
	end
	endcase
end

always @(posedge i_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		wk_state_reg <= `UAID_WK_IDLE;
		wk_cnt_reg <= `UAID_CNT_ZERO;
		rx_prev_reg <= 1'b1;
		o_wake <= 1'b0;
		o_rx_discard <= 1'b0;
	end else begin
		wk_state_reg <= wk_state_next;
		wk_cnt_reg <= wk_cnt_next;
		rx_prev_reg <= i_rx_pin;
		// wake pulse needs the rx interrupt enable but fires whatever the interrupt controller enables
		o_wake <= (wk_state_reg == `UAID_WK_IDLE) & (wk_state_next == `UAID_WK_START);
		o_rx_discard <= (wk_state_next == `UAID_WK_START);
	end
end

////////////////////////////////////////////////////////////////////////////////
// combined request and status

always @* begin
	irq_next = (src_rx | src_ovr | src_txe | src_txi | wake_irq_next) &
		irq_ctrl_reg[`UAID_IC_UART] & irq_ctrl_reg[`UAID_IC_GLOBAL];
	status_next = `UAID_ST_RST;
	status_next[`UAID_ST_RX_AVAIL] = i_rx_avail_flag;
	status_next[`UAID_ST_OVERRUN] = i_overrun_flag;
	status_next[`UAID_ST_TX_EMPTY] = i_tx_empty_flag;
	status_next[`UAID_ST_TX_IDLE] = i_tx_idle_flag;
	status_next[`UAID_ST_ADDR_WORD] = i_rx_avail_flag & top_bit;
	status_next[`UAID_ST_STARTUP] = (wk_state_next == `UAID_WK_START);
end

always @(posedge i_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		o_uart_irq <= 1'b0;
		uart_status_reg <= `UAID_ST_RST;
		o_tx_run <= 1'b0;
		o_rx_run <= 1'b0;
		o_nine_bit_sel <= 1'b0;
		o_parity_en <= 1'b0;
		o_port_on <= 1'b0;
		o_receiver_on <= 1'b0;
	end else begin
		o_uart_irq <= irq_next;
		// flags mirror the serial unit except the start-up bit, which follows the wake sequencer and clears when it ends
		uart_status_reg <= status_next;
		o_tx_run <= ~i_power_down;
		o_rx_run <= ~i_power_down;
		o_nine_bit_sel <= uart_ctrl_one_reg[`UAID_C1_NINE_BIT];
		o_parity_en <= uart_ctrl_one_reg[`UAID_C1_PARITY_EN];
		o_port_on <= uart_ctrl_one_reg[`UAID_C1_PORT_ON];
		o_receiver_on <= uart_ctrl_two_reg[`UAID_C2_RECEIVER_ON];
	end
end

endmodule // uaid_irq_qualifier

// ### uaid_irq_qualifier_props.sv
// port checker of the serial interrupt qualifier
`timescale 1ns/1ns
module uaid_irq_qualifier_props #(
	parameter [15:0] STARTUP_CYCLES = 16'h0400
) (
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_s_axi_arvalid,
	input wire o_s_axi_arready,
	input wire i_s_axi_bready,
	input wire o_s_axi_bvalid,
	input wire [1:0] o_s_axi_bresp,
	input wire i_s_axi_rready,
	input wire o_s_axi_rvalid,
	input wire [31:0] o_s_axi_rdata,
	input wire i_rx_avail_flag,
	input wire i_overrun_flag,
	input wire i_tx_empty_flag,
	input wire i_tx_idle_flag,
	input wire i_rx_pin,
	input wire i_power_down,
	input wire o_port_on,
	input wire o_nine_bit_sel,
	input wire o_tx_run,
	input wire o_rx_run,
	input wire o_rx_discard,
	input wire o_wake,
	input wire o_uart_irq
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	wire any_src = i_rx_avail_flag | i_overrun_flag | i_tx_empty_flag | i_tx_idle_flag;
	reg [15:0] disc_cnt;
	//////////////////////////////////////////////////////////////////
	// length of the start-up mute
	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) disc_cnt <= 16'h0000;
		else if (o_rx_discard) disc_cnt <= disc_cnt + 16'h0001;
		else disc_cnt <= 16'h0000;
	end
	//////////////////////////////////////////////////////////////////
	a_rd_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
		else $error("read answer late");
	a_rd_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready
		|=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data dropped");
	a_wr_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready
		|=> o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write answer dropped");
	a_run_freeze: assert property (i_power_down [*2] |-> !o_tx_run && !o_rx_run)
		else $error("serial unit not frozen");
	a_cfg_keep: assert property (i_power_down && $past(i_power_down)
		|-> $stable(o_port_on) && $stable(o_nine_bit_sel)) else $error("control changed");
	a_wake_cause: assert property (o_wake
		|-> $past(i_power_down) && !$past(i_rx_pin) && $past(i_rx_pin, 2))
		else $error("wake without rx fall");
	a_wake_pulse: assert property (o_wake |=> !o_wake) else $error("wake too long");
	a_wake_mute: assert property (o_wake |-> o_rx_discard) else $error("rx not muted");
	a_startup_len: assert property ($fell(o_rx_discard)
		|-> disc_cnt == STARTUP_CYCLES) else $error("start-up length wrong");
	a_irq_cause: assert property (o_uart_irq
		|-> $past(any_src) || $fell(o_rx_discard)) else $error("irq without source");
	c_wake: cover property (o_wake);
	c_irq: cover property (o_uart_irq);
	c_wake_irq: cover property ($fell(o_rx_discard) && o_uart_irq);
endmodule // uaid_irq_qualifier_props

bind uaid_irq_qualifier uaid_irq_qualifier_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_props (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_s_axi_arvalid(i_s_axi_arvalid),
	.o_s_axi_arready(o_s_axi_arready), .i_s_axi_bready(i_s_axi_bready),
	.o_s_axi_bvalid(o_s_axi_bvalid), .o_s_axi_bresp(o_s_axi_bresp),
	.i_s_axi_rready(i_s_axi_rready), .o_s_axi_rvalid(o_s_axi_rvalid),
	.o_s_axi_rdata(o_s_axi_rdata), .i_rx_avail_flag(i_rx_avail_flag),
	.i_overrun_flag(i_overrun_flag), .i_tx_empty_flag(i_tx_empty_flag),
	.i_tx_idle_flag(i_tx_idle_flag), .i_rx_pin(i_rx_pin), .i_power_down(i_power_down),
	.o_port_on(o_port_on), .o_nine_bit_sel(o_nine_bit_sel), .o_tx_run(o_tx_run),
	.o_rx_run(o_rx_run), .o_rx_discard(o_rx_discard), .o_wake(o_wake), .o_uart_irq(o_uart_irq));

// ### uaid_rx_sender.sv
// remote serial transmitter driving the receive line
`timescale 1ns/1ns
module uaid_rx_sender #(
	parameter [7:0] BIT_CYC = 8'h03
) (
	input wire i_clk,
	input wire i_go,
	output reg o_rx
);
	reg [9:0] frame_reg = 10'h3ff;
	reg [3:0] bits_reg = 4'h0;
	reg [7:0] tick_reg = 8'h00;
	initial o_rx = 1'h1;
	always @(posedge i_clk) begin
		if (bits_reg == 4'h0) begin
			o_rx <= 1'h1;
			if (i_go) begin
				frame_reg <= {1'h1, 8'h55, 1'h0};
				bits_reg <= 4'ha;
				tick_reg <= 8'h00;
			end
		end else begin
			o_rx <= frame_reg[0];
			if (tick_reg == BIT_CYC - 8'h01) begin
				frame_reg <= {1'h1, frame_reg[9:1]};
				bits_reg <= bits_reg - 4'h1;
				tick_reg <= 8'h00;
			end else tick_reg <= tick_reg + 8'h01;
		end
	end
endmodule // uaid_rx_sender

// ### test_uart_irq_addr_detect_wakeup.sv
// testbench of the serial interrupt qualifier
`timescale 1ns/1ns
`include "uaid_defines.vh"
module test_uart_irq_addr_detect_wakeup;
	reg clk = 1'h0, rst = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	reg arvalid = 1'h0, rready = 1'h0, avail = 1'h0, ovr = 1'h0, txe = 1'h0, txi = 1'h0;
	reg pd = 1'h0, idz = 1'h0, slp = 1'h0, go = 1'h0;
	reg [3:0] awaddr = 4'h0, araddr = 4'h0, strb = 4'hf;
	reg [31:0] wdata = 32'h0, rd;
	reg [8:0] head = 9'h000;
	reg [1:0] rs, br;
	wire rx, awready, wready, bvalid, arready, rvalid, irq, wake, disc, txrun, rxrun, pon;
	wire nbs, par, rxon;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	integer failures = 0, check_count = 0, i, j, k, c;
	always #10 clk = ~clk;
	uaid_irq_qualifier #(.STARTUP_CYCLES(16'h0004)) u_dut (.i_clk(clk), .i_sys_rst(rst),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(strb), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_rx_avail_flag(avail),
		.i_rx_head_word(head), .i_overrun_flag(ovr), .i_tx_empty_flag(txe),
		.i_tx_idle_flag(txi), .i_rx_pin(rx), .i_power_down(pd), .i_idle_zero_mode(idz),
		.i_sleep_mode(slp), .o_nine_bit_sel(nbs), .o_parity_en(par), .o_port_on(pon),
		.o_receiver_on(rxon), .o_tx_run(txrun), .o_rx_run(rxrun), .o_rx_discard(disc),
		.o_wake(wake), .o_uart_irq(irq));
	uaid_rx_sender u_far (.i_clk(clk), .i_go(go), .o_rx(rx));
	//////////////////////////////////////////////////////////////////
	task chk_word(input [31:0] got, input [31:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("MISMATCH %0t word %h expected %h", $time, got, exp);
			end
		end
	endtask
	task chk_bit(input logic got, input logic exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("MISMATCH %0t bit %b expected %b", $time, got, exp);
			end
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'h1;
			wvalid <= 1'h1;
			bready <= 1'h1;
			@(posedge clk);
			while (!bvalid) begin
				if (awready) awvalid <= 1'h0;
				if (wready) wvalid <= 1'h0;
				@(posedge clk);
			end
			br = bresp;
			bready <= 1'h0;
			@(posedge clk);
		end
	endtask
	task chk_rd(input [3:0] a, input [31:0] exp, input [1:0] er);
		begin
			araddr <= a;
			arvalid <= 1'h1;
			rready <= 1'h1;
			@(posedge clk);
			while (!rvalid) begin
				if (arready) arvalid <= 1'h0;
				@(posedge clk);
			end
			rd = rdata;
			rs = rresp;
			rready <= 1'h0;
			@(posedge clk);
			chk_word(rd, exp);
			chk_word({30'h0, rs}, {30'h0, er});
		end
	endtask
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", check_count, failures);
			if (failures == 0 && check_count > 0) $display("[ PASS ]");
			else $display("[ FAIL ]");
			$finish;
		end
	endtask
	//////////////////////////////////////////////////////////////////
	initial begin
		repeat (200 * 20) @(posedge clk);
		failures = failures + 1;
		end_of_test;
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		for (i = 0; i < 4; i = i + 1) chk_rd({i[1:0], 2'h0}, 32'h0, `UAID_RESP_OKAY);
		chk_rd(4'h6, 32'h0, `UAID_RESP_SLVERR);
		wr(4'h6, 32'h1);
		chk_word({30'h0, br}, {30'h0, `UAID_RESP_SLVERR});
		wr(`UAID_OFS_STATUS, 32'h3f);
		chk_word({30'h0, br}, {30'h0, `UAID_RESP_OKAY});
		chk_rd(`UAID_OFS_STATUS, 32'h0, `UAID_RESP_OKAY);
		// lane 0 strobe low: write answered but dropped
		strb <= 4'h0;
		wr(`UAID_OFS_CTRL_ONE, 32'h7);
		strb <= 4'hf;
		chk_word({30'h0, br}, {30'h0, `UAID_RESP_OKAY});
		chk_rd(`UAID_OFS_CTRL_ONE, 32'h0, `UAID_RESP_OKAY);
		wr(`UAID_OFS_IRQ_CTRL, 32'h3);
		for (k = 0; k < 4; k = k + 1) begin
			wr(`UAID_OFS_CTRL_ONE, {29'h0, 1'h0, k[1], 1'h1});
			wr(`UAID_OFS_CTRL_TWO, {28'h0, 2'h2, k[0], 1'h1});
			for (j = 0; j < 4; j = j + 1) begin
				head <= {j[1], j[0], 7'h2a};
				avail <= 1'h1;
				repeat (3) @(posedge clk);
				chk_bit(irq, !k[0] || (k[1] ? j[1] : j[0]));
				chk_rd(`UAID_OFS_STATUS, {27'h0, k[1] ? j[1] : j[0], 4'h1}, 2'h0);
			end
		end
		wr(`UAID_OFS_CTRL_TWO, 32'h09);
		for (k = 0; k < 4; k = k + 1) begin
			wr(`UAID_OFS_IRQ_CTRL, k);
			repeat (3) @(posedge clk);
			chk_bit(irq, k == 3);
		end
		avail <= 1'h0;
		// address detect is off here, so parity may be on
		wr(`UAID_OFS_CTRL_ONE, 32'h7);
		for (k = 0; k < 3; k = k + 1) begin
			{txi, txe, ovr} <= 3'h1 << k;
			wr(`UAID_OFS_CTRL_TWO, 32'h01);
			repeat (3) @(posedge clk);
			chk_bit(irq, 1'h0);
			wr(`UAID_OFS_CTRL_TWO, 32'h01 | (32'h8 << k));
			repeat (3) @(posedge clk);
			chk_bit(irq, 1'h1);
			chk_rd(`UAID_OFS_STATUS, {28'h0, 3'h1 << k, 1'h0}, 2'h0);
		end
		chk_bit(nbs, 1'h1);
		chk_bit(par, 1'h1);
		chk_bit(rxon, 1'h1);
		{txi, txe, ovr} <= 3'h0;
		wr(`UAID_OFS_CTRL_ONE, 32'h1);
		for (k = 0; k < 2; k = k + 1) begin
			wr(`UAID_OFS_IRQ_CTRL, k ? 32'h0 : 32'h3);
			wr(`UAID_OFS_CTRL_TWO, 32'h0d);
			idz <= !k[0];
			slp <= k[0];
			pd <= 1'h1;
			repeat (3) @(posedge clk);
			chk_bit(txrun, 1'h0);
			chk_bit(rxrun, 1'h0);
			chk_bit(pon, 1'h1);
			go <= 1'h1;
			@(posedge clk);
			go <= 1'h0;
			while (!wake) @(posedge clk);
			chk_bit(disc, 1'h1);
			c = 0;
			while (disc) begin
				chk_bit(irq, 1'h0);
				c = c + 1;
				@(posedge clk);
			end
			chk_word(c, 32'h4);
			chk_bit(irq, !k[0]);
			pd <= 1'h0;
			repeat (40) @(posedge clk);
			chk_bit(txrun, 1'h1);
			chk_bit(rxrun, 1'h1);
			chk_rd(`UAID_OFS_CTRL_TWO, 32'h0d, `UAID_RESP_OKAY);
			chk_rd(`UAID_OFS_CTRL_ONE, 32'h01, `UAID_RESP_OKAY);
		end
		end_of_test;
	end
endmodule // test_uart_irq_addr_detect_wakeup
